// >>> core/irq1_pkg.sv
/*
 * Shared constants for the first interrupt bank: word indices of the flag,
 * mask and raw status registers, field positions, reset values and the
 * layout of the raw status inputs.
 * Assumes a 32-bit APB slave in which register index n sits at byte 4*n.
 */
package irq1_pkg;
    localparam int REG_W     = 16;
    localparam int FLAG_REGS = 7;
    localparam int FLAG_BITS = REG_W * FLAG_REGS;
    localparam int MASK_REGS = 32;
    localparam int IDX_W     = 14;
    localparam int ADDR_W    = 16;

    localparam logic [IDX_W-1:0] IDX_WATERMARK    = 14'h1817;
    localparam logic [IDX_W-1:0] IDX_TRANSFER     = 14'h1818;
    localparam logic [IDX_W-1:0] IDX_FIRST_START  = 14'h181a;
    localparam logic [IDX_W-1:0] IDX_SECOND_START = 14'h181b;
    localparam logic [IDX_W-1:0] IDX_BUSY         = 14'h181d;
    localparam logic [IDX_W-1:0] IDX_MEMIF_DONE   = 14'h181e;
    localparam logic [IDX_W-1:0] IDX_MEMIF_BLOCK  = 14'h181f;
    localparam logic [IDX_W-1:0] IDX_FLAG_FIRST   = 14'h1800;
    localparam logic [IDX_W-1:0] IDX_MASK_FIRST   = 14'h1840;
    localparam logic [IDX_W-1:0] IDX_BOOT_RAW     = 14'h1880;
    localparam logic [IDX_W-1:0] IDX_LOOP_RAW     = 14'h1881;
    localparam logic [IDX_W-1:0] IDX_JACK_RAW     = 14'h1886;
    localparam logic [IDX_W-1:0] IDX_CONV_RAW     = 14'h1888;
    localparam logic [IDX_W-1:0] IDX_SHORT_RAW    = 14'h188b;
    localparam logic [IDX_W-1:0] IDX_ENDONE_RAW   = 14'h188c;

    localparam logic [IDX_W-1:0] FLAG_IDX [FLAG_REGS] = '{IDX_WATERMARK, IDX_TRANSFER,
        IDX_FIRST_START, IDX_SECOND_START, IDX_BUSY, IDX_MEMIF_DONE, IDX_MEMIF_BLOCK};
    localparam logic [REG_W-1:0] FLAG_USED [FLAG_REGS] = '{16'h00ff, 16'h007f, 16'h007f,
        16'h007f, 16'h007f, 16'h0007, 16'h0007};

    localparam logic [REG_W-1:0] FLAG_RESET      = 16'h0000;
    localparam logic [REG_W-1:0] MASK_RESET      = 16'hffff;
    localparam logic [REG_W-1:0] BOOT_MASK_RESET = 16'hff7f;
    localparam int               BOOT_MASK_SLOT  = 0;

    localparam int POS_CTRL_ERR = 12;
    localparam int POS_BOOT     = 7;
    localparam int POS_LOOP_LO  = 8;
    localparam int POS_CLAMP    = 4;
    localparam int POS_JACK2    = 2;
    localparam int POS_JACK1    = 0;
    localparam int POS_CONV_LO  = 8;
    localparam int POS_SIG_LO   = 0;

    typedef struct packed {
        logic [7:0] enable_done;
        logic [7:0] shorted;
        logic [1:0] signal;
        logic [3:0] conv_lock;
        logic       jack2_pin;
        logic       jack1_pin;
        logic       clamp;
        logic [2:0] loop_lock;
        logic       boot_done;
        logic       ctrl_err;
    } raw_in_s;

    function automatic logic [2:0] flag_slot(input logic [IDX_W-1:0] idx);
        logic [2:0] slot;
        slot = 3'd7;
        for (int i = 0; i < FLAG_REGS; i++) begin
            if (idx == FLAG_IDX[i]) begin
                slot = 3'(i);
            end
        end
        return slot;
    endfunction : flag_slot
endpackage : irq1_pkg

// >>> core/flag_port_if.sv
/*
 * Carrier between the register front end and the sticky flag bank:
 * event levels and write-one clears in, flag state out.
 * Assumes both ends run on the same clock.
 */
interface flag_port_if;
    import irq1_pkg::*;
    logic [FLAG_BITS-1:0] level;
    logic [FLAG_BITS-1:0] clear;
    logic [FLAG_BITS-1:0] flag;
    modport bank (input level, input clear, output flag);
    modport owner (output level, output clear, input flag);
endinterface : flag_port_if

// >>> core/input_sync.sv
/*
 * Two-stage synchroniser for a vector of asynchronous levels.
 * Assumes each bit is an independent slow level; no word coherence.
 */
module input_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= d;
            sync_reg <= meta_reg;
        end
    end

    assign q = sync_reg;
endmodule : input_sync

// >>> core/flag_bank.sv
/*
 * Sticky rising-edge flags with write-one clear.
 * Assumes levels come from logic on the same clock.
 */
module flag_bank
    import irq1_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  rst,
    flag_port_if.bank  port
);
    logic [FLAG_BITS-1:0] prev_reg;
    logic [FLAG_BITS-1:0] flag_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            prev_reg <= '0;
        end else begin
            prev_reg <= port.level;
        end
    end

    // new edge outranks a clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            flag_reg <= '0;
        end else begin
            flag_reg <= (flag_reg & ~port.clear) | (port.level & ~prev_reg);
        end
    end

    assign port.flag = flag_reg;
endmodule : flag_bank

// >>> core/irq1_flag_mask_raw_status.sv
/*
 * First interrupt bank: sticky edge flags for event-log watermarks, core
 * transfer, start and busy events and memory-interface done/block, a mask
 * array, read-only raw status and a level interrupt output, all on APB.
 * Assumes event levels come from same-clock logic; raw status levels and
 * jack pins are asynchronous and pass a synchroniser.
 */
module irq1_flag_mask_raw_status
    import irq1_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [7:0]        log_watermark_level,
    input  wire logic [6:0]        core_transfer_level,
    input  wire logic [6:0]        core_first_start_level,
    input  wire logic [6:0]        core_second_start_level,
    input  wire logic [6:0]        core_busy_level,
    input  wire logic [2:0]        memif_complete_level,
    input  wire logic [2:0]        memif_blocked_level,
    input  wire logic              host_port_error_raw,
    input  wire logic              boot_complete_raw,
    input  wire logic [2:0]        loop_locked_raw,
    input  wire logic              mic_clamp_active_raw,
    input  wire logic              jack_sense_pin1,
    input  wire logic              jack_sense_pin2,
    input  wire logic [3:0]        converter_locked_raw,
    input  wire logic [1:0]        range_proc_signal_raw,
    input  wire logic [7:0]        output_short_raw,
    input  wire logic [7:0]        output_enable_done_raw,
    output logic                   irq
);
    raw_in_s               raw_async;
    raw_in_s               raw_sync;
    logic [IDX_W-1:0]      idx;
    logic                  setup_phase;
    logic                  write_fire;
    logic [REG_W-1:0]      lanes;
    logic [2:0]            slot;
    logic                  mask_hit;
    logic [IDX_W-1:0]      mask_off;
    logic [4:0]            mask_slot;
    logic [REG_W-1:0]      mask_reg [MASK_REGS];
    logic [FLAG_REGS-1:0]  pending;
    logic                  irq_reg;
    logic [REG_W-1:0]      rd_next;
    logic                  err_next;
    logic [31:0]           rdata_reg;
    logic                  err_reg;

    flag_port_if flags ();

    // raw status levels cross in from outside this clock
    assign raw_async.enable_done = output_enable_done_raw;
    assign raw_async.shorted     = output_short_raw;
    assign raw_async.signal      = range_proc_signal_raw;
    assign raw_async.conv_lock   = converter_locked_raw;
    assign raw_async.jack2_pin   = jack_sense_pin2;
    assign raw_async.jack1_pin   = jack_sense_pin1;
    assign raw_async.clamp       = mic_clamp_active_raw;
    assign raw_async.loop_lock   = loop_locked_raw;
    assign raw_async.boot_done   = boot_complete_raw;
    assign raw_async.ctrl_err    = host_port_error_raw;

    input_sync #(
        .W ($bits(raw_in_s))
    ) u_raw_sync (
        .clk (clk),
        .rst (rst),
        .d   (raw_async),
        .q   (raw_sync)
    );

    // event levels, one 16-bit lane per flag register; spare bits never rise
    assign flags.level[0*REG_W +: REG_W] = {8'h00, log_watermark_level};
    assign flags.level[1*REG_W +: REG_W] = {9'h000, core_transfer_level};
    assign flags.level[2*REG_W +: REG_W] = {9'h000, core_first_start_level};
    assign flags.level[3*REG_W +: REG_W] = {9'h000, core_second_start_level};
    assign flags.level[4*REG_W +: REG_W] = {9'h000, core_busy_level};
    assign flags.level[5*REG_W +: REG_W] = {13'h0000, memif_complete_level};
    assign flags.level[6*REG_W +: REG_W] = {13'h0000, memif_blocked_level};

    flag_bank u_flags (
        .clk  (clk),
        .rst  (rst),
        .port (flags)
    );

    // APB decode: register index n lives at byte address 4*n
    assign idx         = paddr[ADDR_W-1:2];
    assign setup_phase = psel & ~penable;
    assign write_fire  = psel & penable & pwrite;
    assign lanes       = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    assign slot        = flag_slot(idx);
    assign mask_off    = idx - IDX_MASK_FIRST;
    assign mask_hit    = (idx >= IDX_MASK_FIRST) && (mask_off < IDX_W'(MASK_REGS));
    assign mask_slot   = mask_off[4:0];
    assign pready      = 1'b1;

    // write-one clear; zero bits and closed byte lanes leave flags alone
    generate
        for (genvar g = 0; g < FLAG_REGS; g++) begin : g_clear
            assign flags.clear[g*REG_W +: REG_W] =
                (write_fire && slot == 3'(g)) ? (pwdata[REG_W-1:0] & lanes & FLAG_USED[g])
                                              : FLAG_RESET;
        end
    endgenerate

    // mask array, one word per index of the 32-index flag window, mirrored 64 indices up
    generate
        for (genvar m = 0; m < MASK_REGS; m++) begin : g_mask
            always_ff @(posedge clk) begin
                if (rst) begin
                    mask_reg[m] <= (m == BOOT_MASK_SLOT) ? BOOT_MASK_RESET : MASK_RESET;
                end else if (write_fire && mask_hit && mask_slot == 5'(m)) begin
                    mask_reg[m] <= (mask_reg[m] & ~lanes) | (pwdata[REG_W-1:0] & lanes);
                end
            end
        end
    endgenerate

    // per-register pending: flag set and mask bit clear
    generate
        for (genvar p = 0; p < FLAG_REGS; p++) begin : g_pend
            localparam logic [IDX_W-1:0] MOFF = FLAG_IDX[p] - IDX_FLAG_FIRST;
            assign pending[p] = |(flags.flag[p*REG_W +: REG_W] & ~mask_reg[MOFF[4:0]]);
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |pending;
        end
    end

    assign irq = irq_reg;

    // read data assembled during setup, held through the access phase
    always_comb begin
        rd_next  = '0;
        err_next = 1'b0;
        if (slot != 3'd7) begin
            rd_next = flags.flag[slot*REG_W +: REG_W];
        end else if (mask_hit) begin
            rd_next = mask_reg[mask_slot];
        end else begin
            unique case (idx)
                IDX_BOOT_RAW: begin
                    rd_next[POS_CTRL_ERR] = raw_sync.ctrl_err;
                    rd_next[POS_BOOT]     = raw_sync.boot_done;
                end
                IDX_LOOP_RAW: begin
                    rd_next[POS_LOOP_LO +: 3] = raw_sync.loop_lock;
                end
                IDX_JACK_RAW: begin
                    rd_next[POS_CLAMP] = raw_sync.clamp;
                    rd_next[POS_JACK2] = ~raw_sync.jack2_pin;
                    rd_next[POS_JACK1] = ~raw_sync.jack1_pin;
                end
                IDX_CONV_RAW: begin
                    rd_next[POS_CONV_LO +: 4] = raw_sync.conv_lock;
                    rd_next[POS_SIG_LO +: 2]  = raw_sync.signal;
                end
                IDX_SHORT_RAW: begin
                    rd_next[7:0] = raw_sync.shorted;
                end
                IDX_ENDONE_RAW: begin
                    rd_next[7:0] = raw_sync.enable_done;
                end
                default: begin
                    err_next = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_reg <= '0;
        end else if (setup_phase) begin
            rdata_reg <= pwrite ? 32'h0000_0000 : {16'h0000, rd_next};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            err_reg <= 1'b0;
        end else if (setup_phase) begin
            err_reg <= err_next;
        end
    end

    assign prdata  = rdata_reg;
    assign pslverr = err_reg & psel & penable;
endmodule : irq1_flag_mask_raw_status

// >>> sim/irq1_checker.sv
/* Port assertions for the first interrupt bank.
   Assumes raw levels stay put for some cycles before a read. */
module irq1_checker
    import irq1_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              irq,
    input wire logic              host_port_error_raw,
    input wire logic              boot_complete_raw,
    input wire logic              mic_clamp_active_raw,
    input wire logic              jack_sense_pin1,
    input wire logic              jack_sense_pin2,
    input wire logic [3:0]        converter_locked_raw,
    input wire logic [1:0]        range_proc_signal_raw
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [2:0]       sc;
    logic [IDX_W-1:0] ix;
    logic             rd;
    logic             mapped;
    logic [10:0]      rv;
    assign ix = paddr[15:2];
    assign rd = psel && penable && !pwrite;
    assign rv = {host_port_error_raw, boot_complete_raw, mic_clamp_active_raw, jack_sense_pin1, jack_sense_pin2,
                 converter_locked_raw, range_proc_signal_raw};
    assign mapped = (ix inside {FLAG_IDX[0], FLAG_IDX[1], FLAG_IDX[2], FLAG_IDX[3], FLAG_IDX[4], FLAG_IDX[5],
        FLAG_IDX[6], IDX_BOOT_RAW, IDX_LOOP_RAW, IDX_JACK_RAW, IDX_CONV_RAW, IDX_SHORT_RAW, IDX_ENDONE_RAW})
        || (ix >= IDX_MASK_FIRST && ix < IDX_MASK_FIRST + 14'd32);
    // cycles since the watched raw levels last moved
    always_ff @(posedge clk) begin
        if (rst || !$stable(rv)) begin
            sc <= 3'd0;
        end else if (sc != 3'd7) begin
            sc <= sc + 3'd1;
        end
    end
    property p_ready; psel && penable |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("pready low in access");
    property p_err_map; psel && penable |-> pslverr == !mapped; endproperty
    a_err_map: assert property (p_err_map) else $error("pslverr wrong for address");
    property p_err_zero; pslverr |-> psel && penable && prdata == 32'h0; endproperty
    a_err_zero: assert property (p_err_zero) else $error("error answer not clean");
    property p_hi_zero; rd |-> prdata[31:16] == 16'h0; endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("upper read bits set");
    property p_irq_rst; $fell(rst) |-> !irq ##1 !irq; endproperty
    a_irq_rst: assert property (p_irq_rst) else $error("irq high after reset");
    property p_boot;
        rd && ix == IDX_BOOT_RAW && sc == 3'd7 |->
            prdata[15:0] == {3'b0, host_port_error_raw, 4'b0, boot_complete_raw, 7'b0};
    endproperty
    a_boot: assert property (p_boot) else $error("boot raw word wrong");
    property p_jack;
        rd && ix == IDX_JACK_RAW && sc == 3'd7 |->
            prdata[15:0] == {11'b0, mic_clamp_active_raw, 1'b0, !jack_sense_pin2, 1'b0, !jack_sense_pin1};
    endproperty
    a_jack: assert property (p_jack) else $error("jack raw word wrong");
    property p_conv;
        rd && ix == IDX_CONV_RAW && sc == 3'd7 |->
            prdata[15:0] == {4'b0, converter_locked_raw, 6'b0, range_proc_signal_raw};
    endproperty
    a_conv: assert property (p_conv) else $error("converter raw word wrong");
    c_unmapped: cover property (pslverr);
    c_irq: cover property ($rose(irq));
    c_raw: cover property (rd && ix == IDX_JACK_RAW && sc == 3'd7);
endmodule : irq1_checker

bind irq1_flag_mask_raw_status irq1_checker u_chk (.*);

// >>> sim/apb_host.sv
/* Host model: APB master that services the interrupt bank.
   Assumes one caller at a time, on the rising clock edge. */
module apb_host
    import irq1_pkg::*;
(
    input  wire logic              clk,
    output logic      [ADDR_W-1:0] paddr,
    output logic                   psel,
    output logic                   penable,
    output logic                   pwrite,
    output logic      [31:0]       pwdata,
    output logic      [3:0]        pstrb,
    input  wire logic [31:0]       prdata,
    input  wire logic              pready,
    input  wire logic              pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    logic booted = 1'b0;
    initial {paddr, psel, penable, pwrite, pwdata, pstrb} = '0;
    task automatic xfer(input logic w, input logic [IDX_W-1:0] idx, input logic [15:0] d, input logic [3:0] s,
                        output logic [15:0] q, output logic e);
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= {idx, 2'b00};
        pwdata <= {16'h0, d};
        pstrb  <= s;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata[15:0];
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic wr(input logic [IDX_W-1:0] idx, input logic [15:0] d, input logic [3:0] s, output logic e);
        logic [15:0] q;
        // no write until the device reports boot done
        while (!booted) begin
            xfer(1'b0, IDX_BOOT_RAW, 16'h0, 4'h0, q, e);
            booted = q[7];
        end
        xfer(1'b1, idx, d, s, q, e);
    endtask : wr
endmodule : apb_host

// >>> sim/tb_irq1_flag_mask_raw_status.sv
/* Self-checking bench for the first interrupt bank.
   Assumes the host model drives the APB side. */
module tb_irq1_flag_mask_raw_status
    import irq1_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [IDX_W-1:0] RAWS [6] = '{IDX_BOOT_RAW, IDX_LOOP_RAW, IDX_JACK_RAW, IDX_CONV_RAW,
                                               IDX_SHORT_RAW, IDX_ENDONE_RAW};
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata;
    logic [3:0]        pstrb, b;
    logic              psel, penable, pwrite, pready, pslverr, irq, e;
    logic [15:0]       lv [FLAG_REGS];
    logic [15:0]       q, m;
    logic [IDX_W-1:0]  mi;
    raw_in_s           r;
    integer            seed = 32'hb944ed74;
    int                num_errors = 0;
    int                checked = 0;
    int                cycles = 0;
    int                fi;
    irq1_flag_mask_raw_status uut (.clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata,
        .pready, .pslverr, .irq, .log_watermark_level(lv[0][7:0]), .core_transfer_level(lv[1][6:0]),
        .core_first_start_level(lv[2][6:0]), .core_second_start_level(lv[3][6:0]),
        .core_busy_level(lv[4][6:0]), .memif_complete_level(lv[5][2:0]), .memif_blocked_level(lv[6][2:0]),
        .host_port_error_raw(r.ctrl_err), .boot_complete_raw(r.boot_done), .loop_locked_raw(r.loop_lock),
        .mic_clamp_active_raw(r.clamp), .jack_sense_pin1(r.jack1_pin), .jack_sense_pin2(r.jack2_pin),
        .converter_locked_raw(r.conv_lock), .range_proc_signal_raw(r.signal), .output_short_raw(r.shorted),
        .output_enable_done_raw(r.enable_done));
    apb_host host (.clk, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr);
    initial forever #10 clk = ~clk;
    function automatic logic [15:0] raw_exp(input logic [IDX_W-1:0] idx);
        case (idx)
            IDX_BOOT_RAW: return 16'(r.ctrl_err) << 12 | 16'(r.boot_done) << 7;
            IDX_LOOP_RAW: return 16'(r.loop_lock) << 8;
            IDX_JACK_RAW: return 16'(r.clamp) << 4 | 16'(!r.jack2_pin) << 2 | 16'(!r.jack1_pin);
            IDX_CONV_RAW: return 16'(r.conv_lock) << 8 | 16'(r.signal);
            IDX_SHORT_RAW: return 16'(r.shorted);
            default: return 16'(r.enable_done);
        endcase
    endfunction : raw_exp
    task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t reg %h exp %h", $time, got, exp);
        end
    endtask : chk_reg
    task automatic chk_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t bit %b exp %b", $time, got, exp);
        end
    endtask : chk_bit
    task automatic rd(input logic [IDX_W-1:0] idx);
        host.xfer(1'b0, idx, 16'h0, 4'h0, q, e);
    endtask : rd
    task automatic print_verdict();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            print_verdict();
        end
    end
    initial begin
        for (fi = 0; fi < FLAG_REGS; fi++) lv[fi] = '0;
        r = '0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        for (fi = 0; fi < FLAG_REGS; fi++) begin
            rd(FLAG_IDX[fi]);
            chk_reg(q, 16'h0);
        end
        for (fi = 0; fi < MASK_REGS; fi++) begin
            rd(IDX_MASK_FIRST + 14'(fi));
            chk_reg(q, fi == 0 ? 16'hff7f : 16'hffff);
        end
        for (int n = 0; n < 8; n++) begin
            r <= (n == 0) ? 30'h3fffffff : 30'($random(seed));
            repeat (9) @(posedge clk);
            for (fi = 0; fi < 6; fi++) begin
                rd(RAWS[fi]);
                chk_reg(q, raw_exp(RAWS[fi]));
            end
        end
        r.boot_done <= 1'b0;
        fork
            begin repeat (20) @(posedge clk); r.boot_done <= 1'b1; end
        join_none
        host.wr(IDX_SHORT_RAW, 16'hffff, 4'h3, e);
        rd(IDX_SHORT_RAW);
        chk_reg(q, raw_exp(IDX_SHORT_RAW));
        rd(14'h1819);
        chk_bit(e, 1'b1);
        host.wr(IDX_MASK_FIRST + 14'd32, 16'h0, 4'h3, e);
        chk_bit(e, 1'b1);
        host.wr(IDX_MASK_FIRST + 14'd1, 16'h1234, 4'h1, e);
        rd(IDX_MASK_FIRST + 14'd1);
        chk_reg(q, 16'hff34);
        for (fi = 0; fi < FLAG_REGS; fi++) begin
            mi = IDX_MASK_FIRST + FLAG_IDX[fi] - IDX_FLAG_FIRST;
            repeat (3) begin
                do b = 4'($random(seed)); while (!FLAG_USED[fi][b]);
                m = 16'h1 << b;
                lv[fi][b] <= 1'b1;
                rd(FLAG_IDX[fi]);
                chk_reg(q, m);
                chk_bit(irq, 1'b0);
                host.wr(mi, ~m, 4'h3, e);
                repeat (2) @(posedge clk);
                chk_bit(irq, 1'b1);
                host.wr(FLAG_IDX[fi], ~m, 4'h3, e);
                rd(FLAG_IDX[fi]);
                chk_reg(q, m);
                // a one on a closed byte lane must not clear
                host.wr(FLAG_IDX[fi], m, b[3] ? 4'h1 : 4'h2, e);
                rd(FLAG_IDX[fi]);
                chk_reg(q, m);
                host.wr(FLAG_IDX[fi], m, 4'h3, e);
                repeat (2) @(posedge clk);
                chk_bit(irq, 1'b0);
                rd(FLAG_IDX[fi]);
                chk_reg(q, 16'h0);
                lv[fi][b] <= 1'b0;
                // level rises at the very edge that clears the flag
                fork
                    host.wr(FLAG_IDX[fi], m, 4'h3, e);
                    begin repeat (2) @(posedge clk); lv[fi][b] <= 1'b1; end
                join
                rd(FLAG_IDX[fi]);
                chk_reg(q, m);
                lv[fi][b] <= 1'b0;
                host.wr(FLAG_IDX[fi], m, 4'h3, e);
                host.wr(mi, 16'hffff, 4'h3, e);
            end
        end
        print_verdict();
    end
endmodule : tb_irq1_flag_mask_raw_status
